// *** dv/srs_assertions.sv ***
// assertions for the suspend and resume sequencer
`timescale 1ns/100ps
`default_nettype none
module srs_assertions (
    input wire logic clk, arst_n,
    input wire logic wake_clk_req, usb_core_irq, usb_suspend_flag,
    input wire logic suspend_input_select, irq_input_select,
    input wire logic osc_mcu_control, mcu_power_down,
    input wire logic mcu_suspend_port_pin, mcu_ext_irq_n,
    input wire logic osc_enable, clocks_enable, suspended, restart_irq
);
    logic [12:0] hi_cnt;
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    // cycles the wake request has stayed high, saturating
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n || !wake_clk_req) hi_cnt <= 13'h0000;
        else if (hi_cnt != 13'h1fff) hi_cnt <= hi_cnt + 13'h0001;
    a_susp_entry: assert property (
        $fell(wake_clk_req) && restart_irq |-> ##[1:6] suspended)
        else $error("suspend not entered");
    a_osc_stop: assert property (
        (osc_mcu_control && mcu_power_down && suspended) [*3]
        |-> !osc_enable && !clocks_enable) else $error("clocks still on");
    a_wake_on: assert property (
        $rose(wake_clk_req) && suspended |-> ##[2:6] osc_enable && clocks_enable)
        else $error("clocks not restarted");
    a_stab_count: assert property (
        $rose(restart_irq) |-> hi_cnt >= 2048 && hi_cnt <= 2070)
        else $error("stabilisation count wrong");
    a_irq_edge: assert property (
        $rose(restart_irq) && irq_input_select |=> mcu_ext_irq_n)
        else $error("no interrupt edge");
    a_restart_hold: assert property (
        $fell(restart_irq) |-> ##[0:2] suspended) else $error("restart dropped");
    a_irq_route: assert property (
        (!irq_input_select && $stable(usb_core_irq)) [*5]
        |-> mcu_ext_irq_n == !usb_core_irq) else $error("irq route wrong");
    a_susp_route: assert property (
        ($stable(suspend_input_select) && $stable(wake_clk_req)
        && $stable(usb_suspend_flag)) [*5] |-> mcu_suspend_port_pin ==
        (suspend_input_select ? wake_clk_req : usb_suspend_flag))
        else $error("suspend route wrong");
endmodule : srs_assertions
bind srs_sequencer srs_assertions chk_u (.*);
`default_nettype wire

// *** dv/srs_mcu_model.sv ***
// controller model for the far side of the sequencer
`timescale 1ns/100ps
`default_nettype none
module srs_mcu_model (
    // clock, reset and device outputs
    input  wire logic       clk, arst_n, suspended, mcu_ext_irq_n,
    input  wire logic       init_busy,
    // connect indication and general pin state
    output logic            connect_hidden, pins_parked,
    // controller register bits
    output logic            suspend_input_select, irq_input_select,
    output logic            osc_mcu_control, mcu_power_down,
    output logic [5:0]      analog_power_off
);
    logic irq_q;
    wire  woke = mcu_power_down && mcu_ext_irq_n && !irq_q;
    // connect stays hidden while the device initialises
    assign connect_hidden = init_busy;
    always_ff @(posedge clk or negedge arst_n)
        if (!arst_n) begin
            {suspend_input_select, osc_mcu_control, irq_q} <= 3'h0;
            {mcu_power_down, irq_input_select, analog_power_off} <= 8'h00;
            pins_parked <= 1'b0;
        end else begin
            irq_q <= mcu_ext_irq_n;
            {suspend_input_select, osc_mcu_control} <= 2'h3;
            if (suspended && !mcu_power_down) begin
                {mcu_power_down, irq_input_select, analog_power_off} <= 8'hff;
                pins_parked <= 1'b1;
            end
            if (woke) begin
                {mcu_power_down, irq_input_select, analog_power_off} <= 8'h00;
                pins_parked <= 1'b0;
            end
        end
endmodule : srs_mcu_model
`default_nettype wire

// *** dv/testbench.sv ***
// testbench for the suspend and resume sequencer
`timescale 1ns/100ps
`default_nettype none
module testbench;
    logic clk, arst_n, wake_clk_req, usb_core_irq, usb_suspend_flag;
    logic suspend_input_select, irq_input_select, osc_mcu_control;
    logic mcu_power_down, mcu_suspend_port_pin, mcu_ext_irq_n, init_busy;
    logic osc_enable, clocks_enable, suspended, restart_irq;
    logic [5:0] analog_power_off, analog_enable;
    logic connect_hidden, pins_parked;
    int failures = 0;
    int total_checks = 0;
    srs_sequencer dut_u (.*);
    srs_mcu_model mcu_u (.*);
    task automatic chk(input logic got, input logic exp);
        total_checks++;
        if (got !== exp) begin
            failures++;
            $display("FAIL %0t output mismatch", $time);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // wake request, core interrupt, core suspend flag
    task automatic put(input logic [2:0] v);
        @(posedge clk);
        {wake_clk_req, usb_core_irq, usb_suspend_flag} <= v;
    endtask : put
    task results;
        $display("checks %0d failures %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : results
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end
    initial begin
        #100000;
        failures++;
        results();
    end
    initial begin
        {arst_n, wake_clk_req, usb_core_irq, usb_suspend_flag} = 4'h4;
        repeat (20) @(posedge clk);
        arst_n <= 1'b1;
        tick(6);
        chk(init_busy & osc_enable & mcu_suspend_port_pin, 1'b1);
        chk(connect_hidden, 1'b1);
        put(3'b110);
        tick(5);
        chk(mcu_ext_irq_n, 1'b0);
        put(3'b001);
        tick(8);
        chk(suspended & ~osc_enable & ~clocks_enable, 1'b1);
        chk(analog_enable == 6'h00, 1'b1);
        chk(pins_parked, 1'b1);
        put(3'b101);
        tick(1000);
        chk(osc_enable & clocks_enable & ~restart_irq, 1'b1);
        put(3'b001);
        tick(8);
        chk(suspended, 1'b1);
        $display("test suspend and abort done");
        put(3'b100);
        tick(2040);
        chk(restart_irq, 1'b0);
        for (int k = 0; k < 40 && restart_irq !== 1'b1; k++) tick(1);
        tick(1);
        chk(restart_irq & mcu_ext_irq_n, 1'b1);
        tick(4);
        chk(analog_enable == 6'h3f && suspended === 1'b0, 1'b1);
        put(3'b001);
        tick(8);
        chk(suspended & ~restart_irq, 1'b1);
        $display("test resume and resuspend done");
        results();
    end
endmodule : testbench
`default_nettype wire

// *** hdl/srs_defines.svh ***
// constants for the suspend and resume sequencer
`ifndef SRS_DEFINES_SVH
`define SRS_DEFINES_SVH
`define SRS_CLK_PERIOD_NS   10
`define SRS_STAB_CYCLES     2048
`define SRS_STAB_CNT_W      12
`define SRS_STAB_LAST       12'h7ff
`define SRS_CNT_ZERO        12'h000
`define SRS_CNT_ONE         12'h001
`define SRS_INIT_TIME_MS    20
`define SRS_INIT_CYCLES     (`SRS_INIT_TIME_MS * 1000000 / `SRS_CLK_PERIOD_NS)
`define SRS_INIT_CNT_W      21
`define SRS_PWR_BITS        6
`define SRS_PWR_OFF_ALL     6'h3f
`endif

// *** hdl/srs_edge_sync.sv ***
// two-flop synchroniser with edge detection
`timescale 1ns/100ps
`default_nettype none
module srs_edge_sync (
    // clock and reset
    input  wire logic clk,
    input  wire logic arst_n,
    // pin in, synchronised out
    input  wire logic pin,
    srs_sync_if.src   sync
);
    logic meta;
    logic stable;
    logic prev;
    logic next_meta;
    logic next_stable;
    logic next_prev;

    always_comb begin
        next_meta   = pin;
        next_stable = meta;
        next_prev   = stable;
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            meta   <= 1'b0;
            stable <= 1'b0;
            prev   <= 1'b0;
        end else begin
            meta   <= next_meta;
            stable <= next_stable;
            prev   <= next_prev;
        end
    end

    assign sync.level = stable;
    assign sync.rise  = stable & ~prev;
    assign sync.fall  = ~stable & prev;
endmodule : srs_edge_sync
`default_nettype wire

// *** hdl/srs_pkg.sv ***
// types for the suspend and resume sequencer
package srs_pkg;
    typedef enum logic [1:0] {
        SRS_RUN     = 2'b00,
        SRS_SUSPEND = 2'b01,
        SRS_STAB    = 2'b11,
        SRS_WAKE    = 2'b10
    } srs_state_type;
endpackage : srs_pkg

// *** hdl/srs_sequencer.sv ***
// suspend and resume sequencer with interrupt and suspend pin routing
//
// Operation
// - wake clock falling edge starts suspend
// - power-down stops oscillator and enabled clocks
// - wake clock rise restarts clocks, starts counter
// - terminal count raises interrupt pin edge
// - after resume, next falling edge suspends again
// - select bits choose usb source or wake clock level / restart source
// - power bits: zero on, one off
// - oscillator control bit zero keeps oscillator on
`timescale 1ns/100ps
`default_nettype none
`include "srs_defines.svh"
module srs_sequencer
    import srs_pkg::*;
(
    // clock and reset
    input  wire logic                     clk,
    input  wire logic                     arst_n,
    // usb core outputs
    input  wire logic                     wake_clk_req,
    input  wire logic                     usb_core_irq,
    input  wire logic                     usb_suspend_flag,
    // controller register bits
    input  wire logic                     suspend_input_select,
    input  wire logic                     irq_input_select,
    input  wire logic                     osc_mcu_control,
    input  wire logic [`SRS_PWR_BITS-1:0] analog_power_off,
    input  wire logic                     mcu_power_down,
    // controller pins
    output logic                          mcu_suspend_port_pin,
    output logic                          mcu_ext_irq_n,
    // clock and analog control
    output logic                          osc_enable,
    output logic                          clocks_enable,
    output logic [`SRS_PWR_BITS-1:0]      analog_enable,
    // status
    output logic                          init_busy,
    output logic                          suspended,
    output logic                          restart_irq
);
    srs_sync_if wake_s ();
    srs_sync_if irq_s ();
    srs_sync_if susp_s ();

    srs_edge_sync u_wake (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (wake_clk_req),
        .sync   (wake_s)
    );
    srs_edge_sync u_irq (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (usb_core_irq),
        .sync   (irq_s)
    );
    srs_edge_sync u_susp (
        .clk    (clk),
        .arst_n (arst_n),
        .pin    (usb_suspend_flag),
        .sync   (susp_s)
    );

    srs_state_type               state;
    srs_state_type               next_state;
    logic [`SRS_STAB_CNT_W-1:0]  stab_cnt;
    logic [`SRS_STAB_CNT_W-1:0]  next_stab_cnt;
    logic [`SRS_INIT_CNT_W-1:0]  init_cnt;
    logic [`SRS_INIT_CNT_W-1:0]  next_init_cnt;
    logic                        init_done;
    logic                        next_init_done;
    logic                        restart;
    logic                        next_restart;
    logic                        suspend_out;
    logic                        irq_out;
    logic                        osc_on;
    logic                        next_suspend_out;
    logic                        next_irq_out;
    logic                        next_osc_on;

    localparam logic [`SRS_INIT_CNT_W-1:0] INIT_LAST =
        `SRS_INIT_CNT_W'(`SRS_INIT_CYCLES - 1);

    // power-on initialisation window
    always_comb begin
        next_init_cnt  = init_cnt;
        next_init_done = init_done;
        if (!init_done) begin
            if (init_cnt == INIT_LAST) begin
                next_init_done = 1'b1;
            end else begin
                next_init_cnt = init_cnt + `SRS_INIT_CNT_W'(1);
            end
        end
    end

    // sequencing state
    always_comb begin
        next_state    = state;
        next_stab_cnt = stab_cnt;
        next_restart  = restart;
        case (state)
            SRS_RUN: begin
                if (wake_s.fall) begin
                    next_state = SRS_SUSPEND;
                end
            end
            SRS_SUSPEND: begin
                next_restart = 1'b0;
                if (wake_s.rise) begin
                    next_state    = SRS_STAB;
                    next_stab_cnt = `SRS_CNT_ZERO;
                end
            end
            SRS_STAB: begin
                if (!wake_s.level) begin
                    next_state    = SRS_SUSPEND;
                    next_stab_cnt = `SRS_CNT_ZERO;
                end else if (stab_cnt == `SRS_STAB_LAST) begin
                    next_state   = SRS_WAKE;
                    next_restart = 1'b1;
                end else begin
                    next_stab_cnt = stab_cnt + `SRS_CNT_ONE;
                end
            end
            SRS_WAKE: begin
                next_stab_cnt = `SRS_CNT_ZERO;
                next_state    = SRS_RUN;
            end
            default: begin
                next_state    = SRS_RUN;
                next_stab_cnt = `SRS_CNT_ZERO;
                next_restart  = 1'b0;
            end
        endcase
        if (!wake_s.level) begin
            next_stab_cnt = `SRS_CNT_ZERO;
        end
    end

    // pin routing and clock gating, registered
    always_comb begin
        if (suspend_input_select) begin
            next_suspend_out = wake_s.level;
        end else begin
            next_suspend_out = susp_s.level;
        end
        // restart source drives a rising edge once stable
        if (irq_input_select) begin
            next_irq_out = restart;
        end else begin
            next_irq_out = ~irq_s.level;
        end
        // a false rise just after reset lands in run state, harmless
        // oscillator held on unless controller may stop it
        next_osc_on = !osc_mcu_control || !mcu_power_down
                      || (state == SRS_STAB) || (state == SRS_WAKE)
                      || wake_s.rise;
    end

    // initialisation window registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            init_cnt    <= '0;
            init_done   <= 1'b0;
        end else begin
            init_cnt    <= next_init_cnt;
            init_done   <= next_init_done;
        end
    end

    // sequencing registers
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state       <= SRS_RUN;
            stab_cnt    <= `SRS_CNT_ZERO;
            restart     <= 1'b0;
        end else begin
            state       <= next_state;
            stab_cnt    <= next_stab_cnt;
            restart     <= next_restart;
        end
    end

    // pin and clock registers; idle levels hold during reset
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            suspend_out <= 1'b0;
            irq_out     <= 1'b1;
            osc_on      <= 1'b1;
        end else begin
            suspend_out <= next_suspend_out;
            irq_out     <= next_irq_out;
            osc_on      <= next_osc_on;
        end
    end

    assign mcu_suspend_port_pin = suspend_out;
    assign mcu_ext_irq_n        = irq_out;
    assign osc_enable           = osc_on;
    assign clocks_enable        = osc_on;
    assign analog_enable        = ~analog_power_off;
    assign init_busy            = ~init_done;
    assign suspended            = (state == SRS_SUSPEND);
    assign restart_irq          = restart;
endmodule : srs_sequencer
`default_nettype wire

// *** hdl/srs_sync_if.sv ***
// interface carrying a synchronised pin and its edges
`timescale 1ns/100ps
`default_nettype none
interface srs_sync_if;
    logic level;
    logic rise;
    logic fall;
    modport src (output level, output rise, output fall);
    modport dst (input level, input rise, input fall);
endinterface : srs_sync_if
`default_nettype wire
